// ### inc/cpu_decode_pkg.sv
// How it works
// - Opcode 00 is the one-byte supervisory call, 15 cycles.
// - Opcode 30 is the one-byte halt, 9 cycles.
// - Halt writes the system control register at user address FFh.
// - Interrupt acknowledge to vector table takes 13 cycles.
// - Instruction straddling a 128-byte flash page costs one extra cycle.
// - Instruction bytes come over a dedicated flash fetch bus.
// - Seven formats of one, two or three bytes, opcode first.
// - No-op only advances the program counter; supervisory call also pulses syscall_start.
// - Both pushes write RAM and bump the stack pointer.
// - Other one-byte instructions touch only core registers or SRAM.
// - Short jumps and calls carry a 12-bit two's-complement offset.
// - Source-immediate form is opcode then 8-bit constant into a core register.
// - Direct, indexed and indirect modes are opcode then 8-bit address.
// - Opcodes 3E and 3F are two-byte indirect post-increment moves, 10 cycles.
// - Opcode 3C compares RAM with constant, 8 cycles, sets zero and carry.
// - Opcodes 70-72 AND/OR/XOR the flags with a constant, 4 cycles.
// - Opcode 5F is a three-byte memory-to-memory move, 10 cycles.
// - Opcode 5D reads register space into the accumulator, 6 cycles.
package cpu_decode_pkg;
   localparam logic [7:0] OP_SUPERVISORY_CALL = 8'h00;
   localparam logic [7:0] OP_PUSH_A           = 8'h08;
   localparam logic [7:0] OP_PUSH_X           = 8'h10;
   localparam logic [7:0] OP_HALT             = 8'h30;
   localparam logic [7:0] OP_CMP_MEM_IMM      = 8'h3C;
   localparam logic [7:0] OP_MVI_LOAD         = 8'h3E;
   localparam logic [7:0] OP_MVI_STORE        = 8'h3F;
   localparam logic [7:0] OP_NOP              = 8'h40;
   localparam logic [7:0] OP_READ_REG         = 8'h5D;
   localparam logic [7:0] OP_MOVE_MEM_MEM     = 8'h5F;
   localparam logic [7:0] OP_FLAG_AND         = 8'h70;
   localparam logic [7:0] OP_FLAG_OR          = 8'h71;
   localparam logic [7:0] OP_FLAG_XOR         = 8'h72;
   localparam logic [7:0] OP_LONG_CALL        = 8'h7C;
   localparam logic [7:0] OP_LONG_JUMP        = 8'h7D;
   localparam logic [3:0] NIB_SHORT_JUMP      = 4'h8;
   localparam logic [3:0] NIB_SHORT_CALL      = 4'h9;
   localparam logic [4:0] CYC_SUPERVISORY     = 5'h0F;
   localparam logic [4:0] CYC_HALT            = 5'h09;
   localparam logic [4:0] CYC_INT_ACK         = 5'h0D;
   localparam logic [4:0] CYC_SHORT_CALL      = 5'h0B;
   localparam logic [4:0] CYC_MVI             = 5'h0A;
   localparam logic [4:0] CYC_CMP_MEM_IMM     = 5'h08;
   localparam logic [4:0] CYC_FLAG_OP         = 5'h04;
   localparam logic [4:0] CYC_MOVE_MEM_MEM    = 5'h0A;
   localparam logic [4:0] CYC_READ_REG        = 5'h06;
   localparam logic [4:0] CYC_DEFAULT         = 5'h06;
   localparam logic [4:0] CYC_HEAD            = 5'h03;
   localparam int         PAGE_BITS           = 7;
   localparam logic [7:0] SYS_CTRL_ADDR       = 8'hFF;
   localparam logic [7:0] SYS_CTRL_STOP       = 8'h01;
   localparam int         FLAG_CARRY          = 2;
   localparam int         FLAG_ZERO           = 1;
   localparam logic [15:0] RESET_PC           = 16'h0000;

   typedef enum logic [2:0] {
      FMT_ONE       = 3'b000,
      FMT_REL12     = 3'b001,
      FMT_IMM8      = 3'b010,
      FMT_ADDR8     = 3'b011,
      FMT_ABS16     = 3'b100,
      FMT_ADDR_IMM  = 3'b101,
      FMT_ADDR_ADDR = 3'b110
   } format_t;

   typedef enum logic [1:0] {
      EFF_NONE     = 2'b00,
      EFF_RAM      = 2'b01,
      EFF_USER_REG = 2'b10,
      EFF_CORE     = 2'b11
   } effect_t;

   typedef enum logic [2:0] {
      ST_FIRST  = 3'b000,
      ST_OPCODE = 3'b001,
      ST_EXEC   = 3'b010,
      ST_INT    = 3'b011,
      ST_HALT   = 3'b100
   } state_t;
endpackage

// ### sim/cpu_instruction_decode_assertions.sv
`timescale 1ns/10ps
module cpu_instruction_decode_assertions (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        fetch_req,
   input wire logic [15:0] fetch_addr,
   input wire logic [15:0] int_vector,
   input wire logic [7:0]  reg_rd_data,
   input wire logic [7:0]  flags_in,
   input wire logic        ram_wr,
   input wire logic [7:0]  ram_wr_addr,
   input wire logic        sp_inc,
   input wire logic        sys_ctrl_wr,
   input wire logic [7:0]  sys_ctrl_addr,
   input wire logic [7:0]  sys_ctrl_data,
   input wire logic        acc_wr,
   input wire logic [7:0]  acc_data,
   input wire logic        flags_wr,
   input wire logic [7:0]  flags_data,
   input wire logic        int_ack,
   input wire logic        instr_done,
   input wire logic [7:0]  opcode,
   input wire logic [7:0]  operand1,
   input wire logic [1:0]  instr_len,
   input wire logic [15:0] prog_counter,
   input wire logic        halted
);
   logic [4:0]  gap, next_gap;
   logic [15:0] start, next_start;
   logic        seen, next_seen;
   logic [7:0]  endp;
   // Cycles and start address of the instruction in flight
   always_comb begin
      next_gap   = (instr_done || int_ack) ? 5'h01 : gap + 5'h01;
      next_start = (instr_done || int_ack) ? fetch_addr : start;
      next_seen  = seen || instr_done || int_ack;
   end
   always_ff @(posedge clk) begin
      gap   <= resetn ? next_gap : 5'h00;
      start <= resetn ? next_start : 16'h0000;
      seen  <= resetn && next_seen;
   end
   assign endp = {1'b0, start[6:0]} + {6'h00, instr_len} - 8'h01;
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_cyc(logic [7:0] op, int n);
      instr_done && seen && opcode == op |-> gap == n + endp[7];
   endproperty
   a_cyc_syscall: assert property (p_cyc(8'h00, 15)) else $error("syscall length wrong");
   a_cyc_halt: assert property (p_cyc(8'h30, 9)) else $error("halt length wrong");
   a_cyc_mvi: assert property (p_cyc(8'h3E, 10)) else $error("move length wrong");
   a_call_target: assert property (instr_done && seen && opcode[7:4] == 4'h9 |->
      gap == 11 + endp[7] && prog_counter == start + {{4{opcode[3]}}, opcode[3:0], operand1})
      else $error("short call wrong");
   a_halt_write: assert property (sys_ctrl_wr |-> opcode == 8'h30 && sys_ctrl_addr == 8'hFF
      && sys_ctrl_data == 8'h01 ##1 halted) else $error("halt write wrong");
   a_halt_stop: assert property (halted |-> !fetch_req) else $error("fetch after halt");
   a_ack_vector: assert property (int_ack |-> prog_counter == int_vector && fetch_req
      && $past(instr_done, 13)) else $error("acknowledge wrong");
   a_push_ram: assert property (instr_done && instr_len == 2'h1 |->
      (ram_wr && sp_inc) == (opcode == 8'h08 || opcode == 8'h10)) else $error("push wrong");
   a_quiet_nop: assert property (instr_done && (opcode == 8'h00 || opcode == 8'h40) |->
      !(ram_wr || sp_inc || acc_wr || flags_wr || sys_ctrl_wr)) else $error("nop wrote");
   a_read_reg: assert property (instr_done && opcode == 8'h5D |-> acc_wr && flags_wr
      && acc_data == $past(reg_rd_data) && flags_data[1] == (acc_data == 8'h00))
      else $error("register read wrong");
   a_flag_or: assert property (instr_done && opcode == 8'h71 |-> flags_wr
      && flags_data == ($past(flags_in) | operand1)) else $error("flag op wrong");
   a_move_write: assert property (instr_done && opcode == 8'h5F |-> ram_wr
      && ram_wr_addr == operand1) else $error("memory move wrong");
   c_ack: cover property (int_ack);
   c_cross: cover property (instr_done && seen && endp[7]);
   c_halt: cover property (sys_ctrl_wr);
endmodule
bind cpu_instruction_decode cpu_instruction_decode_assertions chk (.*);

// ### sim/cpu_instruction_decode_tb.sv
`timescale 1ns/10ps
module cpu_instruction_decode_tb;
   import cpu_decode_pkg::*;
   // Address and byte pairs; other locations hold no-operation
   localparam logic [19:0] PROG [22] = '{20'h00100, 20'h00271, 20'h0030C, 20'h0045D,
      20'h00510, 20'h0063E, 20'h00720, 20'h00808, 20'h00990, 20'h00A76, 20'h07F3E,
      20'h08020, 20'h0819F, 20'h082BF, 20'h0405C, 20'h2003C, 20'h20105, 20'h2025B,
      20'h2035F, 20'h20407, 20'h20509, 20'h20630};
   logic clk = 0, resetn = 0, irq = 0, gie = 0, pc_redirect = 0;
   logic fetch_req, ram_wr, sp_inc, sys_ctrl_wr, acc_wr, flags_wr, core_wr;
   logic syscall_start, int_ack, instr_done, halted;
   logic [15:0] fetch_addr, prog_counter, n, int_vector = 16'h0200, pc_redirect_addr = 16'h0000;
   logic [7:0] acc_in = 8'h11, x_in = 8'h22, sp_in = 8'h30, flags_in = 8'h03;
   logic [7:0] ram_rd_data = 8'h5A, reg_rd_data = 8'h00, fetch_data, ram_rd_addr, reg_rd_addr;
   logic [7:0] ram_wr_addr, ram_wr_data, sys_ctrl_addr, sys_ctrl_data, acc_data, flags_data;
   logic [7:0] opcode, operand1, operand2;
   logic [1:0] instr_len;
   format_t    instr_fmt;
   effect_t    instr_effect;
   int         err_total = 0;
   int         compares = 0;
   always #50 clk = ~clk;
   cpu_instruction_decode uut (.*);
   flash_model flash (.clk(clk), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
      .fetch_data(fetch_data));
   task print_verdict;
      if (err_total == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Cycles until completion or acknowledge
   task wait_ev(input bit ack);
      n = 16'h0000;
      do begin
         @(negedge clk);
         n++;
      end while ((ack ? int_ack : instr_done) !== 1'b1 && n < 16'h0040);
      if (n == 16'h0040) err_total++;
   endtask
   task t_quiet;
      wait_ev(0);
      chk({ram_wr, sp_inc, acc_wr, flags_wr, sys_ctrl_wr}, 16'h0000);
      wait_ev(0);
      chk({opcode, n[7:0]}, 16'h000F);
      chk({syscall_start, core_wr, prog_counter[13:0]}, 16'h8002);
      chk({ram_wr, sp_inc, acc_wr, flags_wr, sys_ctrl_wr}, 16'h0000);
   endtask
   task t_flags;
      wait_ev(0);
      chk({n[7:0], flags_data}, 16'h040F);
      chk({9'h000, instr_len, instr_fmt, instr_effect}, 16'h004B);
      wait_ev(0);
      chk({n[6:0], acc_data, flags_data[1]}, 16'h0C01);
      chk({reg_rd_addr, 1'b0, instr_len, instr_fmt, instr_effect}, 16'h104F);
   endtask
   task t_moves;
      wait_ev(0);
      chk({opcode, n[7:0]}, 16'h3E0A);
      chk({core_wr, ram_wr}, 16'h0002);
      wait_ev(0);
      chk({n[7:0], 6'h00, ram_wr, sp_inc}, 16'h0403);
      chk({ram_wr_addr, ram_wr_data}, 16'h3011);
   endtask
   task t_calls;
      wait_ev(0);
      chk(n, 16'h000B);
      chk(prog_counter, 16'h007F);
      wait_ev(0);
      chk({opcode, n[7:0]}, 16'h3E0B);
      wait_ev(0);
      chk(prog_counter, 16'h0040);
      irq = 1'b1;
      gie = 1'b1;
   endtask
   task t_interrupt;
      wait_ev(0);
      chk({n[7:0], 6'h00, core_wr, ram_wr}, 16'h0402);
      wait_ev(1);
      chk(n, 16'h000D);
      chk(prog_counter, 16'h0200);
      irq = 1'b0;
   endtask
   // Compare then memory-to-memory move at the vector
   task t_three;
      wait_ev(0);
      chk({n[7:0], flags_data}, 16'h0805);
      wait_ev(0);
      chk({n[7:0], ram_wr_addr}, 16'h0A07);
      chk({ram_rd_addr, ram_wr_data}, 16'h095A);
      chk({operand1, operand2}, 16'h0709);
   endtask
   task t_halt;
      wait_ev(0);
      chk({n[6:0], sys_ctrl_wr}, 16'h0013);
      chk({sys_ctrl_addr, sys_ctrl_data}, 16'hFF01);
      repeat (4) @(negedge clk);
      chk({halted, fetch_req}, 16'h0002);
      chk(fetch_addr, 16'h0207);
   endtask
   initial begin
      for (int i = 0; i < 1024; i++) flash.mem[i] = 8'h40;
      foreach (PROG[i]) flash.mem[PROG[i][17:8]] = PROG[i][7:0];
      repeat (4) @(negedge clk);
      resetn = 1'b1;
      t_quiet;
      t_flags;
      t_moves;
      t_calls;
      t_interrupt;
      t_three;
      t_halt;
      print_verdict;
   end
   initial begin
      #300000;
      err_total++;
      print_verdict;
   end
endmodule

// ### sim/flash_model.sv
`timescale 1ns/10ps
module flash_model (
   input  wire logic        clk,
   input  wire logic        fetch_req,
   input  wire logic [15:0] fetch_addr,
   output logic [7:0]       fetch_data
);
   logic [7:0] mem [0:1023];
   initial fetch_data = 8'h00;
   // Byte one cycle after its request, idle bus toggles
   always @(posedge clk) fetch_data <= fetch_req ? mem[fetch_addr[9:0]] : ~fetch_data;
endmodule

// ### verilog/cpu_instruction_decode.sv
`timescale 1ns/10ps
module cpu_instruction_decode (
   input  wire logic                    clk,
   input  wire logic                    resetn,
   output logic                         fetch_req,
   output logic [15:0]                  fetch_addr,
   input  wire logic [7:0]              fetch_data,
   input  wire logic                    irq,
   input  wire logic                    gie,
   input  wire logic [15:0]             int_vector,
   input  wire logic                    pc_redirect,
   input  wire logic [15:0]             pc_redirect_addr,
   input  wire logic [7:0]              acc_in,
   input  wire logic [7:0]              x_in,
   input  wire logic [7:0]              sp_in,
   input  wire logic [7:0]              flags_in,
   output logic [7:0]                   ram_rd_addr,
   input  wire logic [7:0]              ram_rd_data,
   output logic [7:0]                   reg_rd_addr,
   input  wire logic [7:0]              reg_rd_data,
   output logic                         ram_wr,
   output logic [7:0]                   ram_wr_addr,
   output logic [7:0]                   ram_wr_data,
   output logic                         sp_inc,
   output logic                         sys_ctrl_wr,
   output logic [7:0]                   sys_ctrl_addr,
   output logic [7:0]                   sys_ctrl_data,
   output logic                         acc_wr,
   output logic [7:0]                   acc_data,
   output logic                         flags_wr,
   output logic [7:0]                   flags_data,
   output logic                         core_wr,
   output logic                         syscall_start,
   output logic                         int_ack,
   output logic                         instr_done,
   output logic [7:0]                   opcode,
   output logic [7:0]                   operand1,
   output logic [7:0]                   operand2,
   output logic [1:0]                   instr_len,
   output cpu_decode_pkg::format_t      instr_fmt,
   output cpu_decode_pkg::effect_t      instr_effect,
   output logic [15:0]                  prog_counter,
   output logic                         halted
);
   import cpu_decode_pkg::*;

   state_t      state;
   state_t      next_state;
   logic [4:0]  cnt;
   logic [4:0]  next_cnt;
   logic [1:0]  step;
   logic [1:0]  next_step;
   logic        redir;
   logic        next_redir;
   logic [15:0] redir_addr;
   logic [15:0] next_redir_addr;
   logic [15:0] next_pc;
   logic [7:0]  next_opcode;
   logic [7:0]  next_op1;
   logic [7:0]  next_op2;
   logic [1:0]  next_len;
   format_t     next_fmt;
   effect_t     next_effect;
   logic        next_ram_wr;
   logic [7:0]  next_ram_wr_addr;
   logic [7:0]  next_ram_wr_data;
   logic        next_sp_inc;
   logic        next_sys_ctrl_wr;
   logic [7:0]  next_sys_ctrl_data;
   logic        next_acc_wr;
   logic [7:0]  next_acc_data;
   logic        next_flags_wr;
   logic [7:0]  next_flags_data;
   logic        next_core_wr;
   logic        next_syscall;
   logic        next_int_ack;
   logic        next_done;
   logic        next_halted;

   logic [1:0]  tbl_len;
   logic [4:0]  tbl_cyc;
   format_t     tbl_fmt;
   effect_t     tbl_effect;
   logic [15:0] last_byte;
   logic        span;
   logic [11:0] rel_off;
   logic [15:0] rel_target;
   logic [7:0]  flag_res;

   opcode_table u_table (
      .opcode (fetch_data),
      .len    (tbl_len),
      .cycles (tbl_cyc),
      .fmt    (tbl_fmt),
      .effect (tbl_effect)
   );

   assign sys_ctrl_addr = SYS_CTRL_ADDR;
   assign ram_rd_addr   = (opcode == OP_MOVE_MEM_MEM) ? operand2 : operand1;
   assign reg_rd_addr   = operand1;

   // Last byte address decides whether the instruction crosses a flash page
   assign last_byte  = prog_counter + {14'h0000, tbl_len} - 16'h0001;
   assign span       = last_byte[15:PAGE_BITS] != prog_counter[15:PAGE_BITS];
   assign rel_off    = {opcode[3:0], operand1};
   assign rel_target = prog_counter + {{4{rel_off[11]}}, rel_off};

   always_comb begin
      case (opcode)
         OP_FLAG_AND: flag_res = flags_in & operand1;
         OP_FLAG_OR:  flag_res = flags_in | operand1;
         default:     flag_res = flags_in ^ operand1;
      endcase
   end

   always_comb begin
      next_state         = state;
      next_cnt           = cnt;
      next_step          = step;
      next_redir         = redir;
      next_redir_addr    = redir_addr;
      next_pc            = prog_counter;
      next_opcode        = opcode;
      next_op1           = operand1;
      next_op2           = operand2;
      next_len           = instr_len;
      next_fmt           = instr_fmt;
      next_effect        = instr_effect;
      next_ram_wr        = 1'b0;
      next_ram_wr_addr   = ram_wr_addr;
      next_ram_wr_data   = ram_wr_data;
      next_sp_inc        = 1'b0;
      next_sys_ctrl_wr   = 1'b0;
      next_sys_ctrl_data = sys_ctrl_data;
      next_acc_wr        = 1'b0;
      next_acc_data      = acc_data;
      next_flags_wr      = 1'b0;
      next_flags_data    = flags_data;
      next_core_wr       = 1'b0;
      next_syscall       = 1'b0;
      next_int_ack       = 1'b0;
      next_done          = 1'b0;
      next_halted        = halted;
      fetch_req          = 1'b0;
      fetch_addr         = prog_counter;
      case (state)
         ST_FIRST: begin
            fetch_req  = 1'b1;
            next_state = ST_OPCODE;
         end
         ST_OPCODE: begin
            next_opcode = fetch_data;
            next_len    = tbl_len;
            next_fmt    = tbl_fmt;
            next_effect = tbl_effect;
            next_op1    = 8'h00;
            next_op2    = 8'h00;
            next_step   = 2'd0;
            next_redir  = 1'b0;
            next_cnt    = tbl_cyc + {4'h0, span} - CYC_HEAD;
            fetch_req   = tbl_len != 2'd1;
            fetch_addr  = prog_counter + 16'h0001;
            next_state  = ST_EXEC;
         end
         ST_EXEC: begin
            if (step == 2'd0) begin
               if (instr_len != 2'd1) begin
                  next_op1 = fetch_data;
               end
               fetch_req  = instr_len == 2'd3;
               fetch_addr = prog_counter + 16'h0002;
               next_step  = 2'd1;
            end else if (step == 2'd1) begin
               if (instr_len == 2'd3) begin
                  next_op2 = fetch_data;
               end
               next_step = 2'd2;
            end
            if (pc_redirect) begin
               next_redir      = 1'b1;
               next_redir_addr = pc_redirect_addr;
            end
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else begin
               next_done = 1'b1;
               next_pc   = prog_counter + {14'h0000, instr_len};
               if (opcode[7:4] == NIB_SHORT_JUMP || opcode[7:4] == NIB_SHORT_CALL) begin
                  next_pc = rel_target;
               end else if (opcode == OP_LONG_CALL || opcode == OP_LONG_JUMP) begin
                  next_pc = {operand1, operand2};
               end
               if (redir) begin
                  next_pc = redir_addr;
               end
               case (opcode)
                  OP_SUPERVISORY_CALL: next_syscall = 1'b1;
                  OP_NOP: next_syscall = 1'b0;
                  OP_PUSH_A, OP_PUSH_X: begin
                     next_ram_wr      = 1'b1;
                     next_ram_wr_addr = sp_in;
                     next_ram_wr_data = (opcode == OP_PUSH_A) ? acc_in : x_in;
                     next_sp_inc      = 1'b1;
                  end
                  OP_HALT: begin
                     next_sys_ctrl_wr   = 1'b1;
                     next_sys_ctrl_data = SYS_CTRL_STOP;
                  end
                  OP_CMP_MEM_IMM: begin
                     next_flags_wr                = 1'b1;
                     next_flags_data              = flags_in;
                     next_flags_data[FLAG_ZERO]   = ram_rd_data == operand2;
                     next_flags_data[FLAG_CARRY]  = ram_rd_data < operand2;
                  end
                  OP_FLAG_AND, OP_FLAG_OR, OP_FLAG_XOR: begin
                     next_flags_wr   = 1'b1;
                     next_flags_data = flag_res;
                  end
                  OP_MOVE_MEM_MEM: begin
                     next_ram_wr      = 1'b1;
                     next_ram_wr_addr = operand1;
                     next_ram_wr_data = ram_rd_data;
                  end
                  OP_READ_REG: begin
                     next_acc_wr                = 1'b1;
                     next_acc_data              = reg_rd_data;
                     next_flags_wr              = 1'b1;
                     next_flags_data            = flags_in;
                     next_flags_data[FLAG_ZERO] = reg_rd_data == 8'h00;
                  end
                  default: begin
                     next_core_wr = instr_effect == EFF_CORE;
                     next_ram_wr  = instr_effect == EFF_RAM;
                  end
               endcase
               if (opcode == OP_HALT) begin
                  next_state  = ST_HALT;
                  next_halted = 1'b1;
               end else if (irq && gie) begin
                  next_cnt   = CYC_INT_ACK - 5'h01;
                  next_state = ST_INT;
               end else begin
                  next_state = ST_FIRST;
               end
            end
         end
         ST_INT: begin
            if (cnt != 5'h00) begin
               next_cnt = cnt - 5'h01;
            end else begin
               next_pc      = int_vector;
               next_int_ack = 1'b1;
               next_state   = ST_FIRST;
            end
         end
         ST_HALT: next_halted = 1'b1;
         default: next_state = ST_FIRST;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         state         <= ST_FIRST;
         cnt           <= 5'h00;
         step          <= 2'd0;
         redir         <= 1'b0;
         redir_addr    <= 16'h0000;
         prog_counter  <= RESET_PC;
         opcode        <= 8'h00;
         operand1      <= 8'h00;
         operand2      <= 8'h00;
         instr_len     <= 2'd1;
         instr_fmt     <= FMT_ONE;
         instr_effect  <= EFF_NONE;
         ram_wr        <= 1'b0;
         ram_wr_addr   <= 8'h00;
         ram_wr_data   <= 8'h00;
         sp_inc        <= 1'b0;
         sys_ctrl_wr   <= 1'b0;
         sys_ctrl_data <= 8'h00;
         acc_wr        <= 1'b0;
         acc_data      <= 8'h00;
         flags_wr      <= 1'b0;
         flags_data    <= 8'h00;
         core_wr       <= 1'b0;
         syscall_start <= 1'b0;
         int_ack       <= 1'b0;
         instr_done    <= 1'b0;
         halted        <= 1'b0;
      end else begin
         state         <= next_state;
         cnt           <= next_cnt;
         step          <= next_step;
         redir         <= next_redir;
         redir_addr    <= next_redir_addr;
         prog_counter  <= next_pc;
         opcode        <= next_opcode;
         operand1      <= next_op1;
         operand2      <= next_op2;
         instr_len     <= next_len;
         instr_fmt     <= next_fmt;
         instr_effect  <= next_effect;
         ram_wr        <= next_ram_wr;
         ram_wr_addr   <= next_ram_wr_addr;
         ram_wr_data   <= next_ram_wr_data;
         sp_inc        <= next_sp_inc;
         sys_ctrl_wr   <= next_sys_ctrl_wr;
         sys_ctrl_data <= next_sys_ctrl_data;
         acc_wr        <= next_acc_wr;
         acc_data      <= next_acc_data;
         flags_wr      <= next_flags_wr;
         flags_data    <= next_flags_data;
         core_wr       <= next_core_wr;
         syscall_start <= next_syscall;
         int_ack       <= next_int_ack;
         instr_done    <= next_done;
         halted        <= next_halted;
      end
   end
endmodule

// ### verilog/opcode_table.sv
`timescale 1ns/10ps
module opcode_table (
   input  wire logic [7:0]              opcode,
   output logic [1:0]                   len,
   output logic [4:0]                   cycles,
   output cpu_decode_pkg::format_t      fmt,
   output cpu_decode_pkg::effect_t      effect
);
   import cpu_decode_pkg::*;

   always_comb begin
      len    = 2'd2;
      cycles = CYC_DEFAULT;
      fmt    = FMT_ADDR8;
      effect = EFF_CORE;
      case (opcode)
         OP_SUPERVISORY_CALL: begin
            len = 2'd1; cycles = CYC_SUPERVISORY; fmt = FMT_ONE; effect = EFF_NONE;
         end
         OP_NOP: begin
            len = 2'd1; cycles = 5'h04; fmt = FMT_ONE; effect = EFF_NONE;
         end
         OP_PUSH_A, OP_PUSH_X: begin
            len = 2'd1; cycles = 5'h04; fmt = FMT_ONE; effect = EFF_RAM;
         end
         OP_HALT: begin
            len = 2'd1; cycles = CYC_HALT; fmt = FMT_ONE; effect = EFF_USER_REG;
         end
         8'h18, 8'h20, 8'h4B, 8'h4E: begin
            len = 2'd1; cycles = 5'h05; fmt = FMT_ONE;
         end
         8'h28: begin
            len = 2'd1; cycles = 5'h0B; fmt = FMT_ONE;
         end
         8'h64, 8'h67, 8'h6D, 8'h73, 8'h74, 8'h75, 8'h78, 8'h79,
         8'h4F, 8'h5B, 8'h5C: begin
            len = 2'd1; cycles = 5'h04; fmt = FMT_ONE;
         end
         8'h7E: begin len = 2'd1; cycles = 5'h0A; fmt = FMT_ONE; end
         8'h7F: begin len = 2'd1; cycles = 5'h08; fmt = FMT_ONE; end
         OP_MVI_LOAD:  cycles = CYC_MVI;
         OP_MVI_STORE: begin cycles = CYC_MVI; effect = EFF_RAM; end
         OP_CMP_MEM_IMM: begin
            len = 2'd3; cycles = CYC_CMP_MEM_IMM; fmt = FMT_ADDR_IMM;
         end
         OP_MOVE_MEM_MEM: begin
            len = 2'd3; cycles = CYC_MOVE_MEM_MEM; fmt = FMT_ADDR_ADDR; effect = EFF_RAM;
         end
         OP_READ_REG: cycles = CYC_READ_REG;
         OP_FLAG_AND, OP_FLAG_OR, OP_FLAG_XOR: begin
            cycles = CYC_FLAG_OP; fmt = FMT_IMM8;
         end
         8'h38, 8'h39, 8'h50, 8'h57: begin
            cycles = (opcode == 8'h38) ? 5'h05 : (opcode == 8'h39) ? 5'h05 : 5'h04;
            fmt    = FMT_IMM8;
         end
         OP_LONG_CALL: begin len = 2'd3; cycles = 5'h0D; fmt = FMT_ABS16; end
         OP_LONG_JUMP: begin len = 2'd3; cycles = 5'h07; fmt = FMT_ABS16; end
         default: begin
            if (opcode[7]) begin
               fmt    = FMT_REL12;
               cycles = (opcode[7:4] == NIB_SHORT_CALL) ? CYC_SHORT_CALL :
                        (opcode[7:4] == 4'hE) ? 5'h07 :
                        (opcode[7:4] == 4'hF) ? 5'h0D : 5'h05;
            end else if (opcode < 8'h38) begin
               case (opcode[2:0])
                  3'd1: begin cycles = 5'h04; fmt = FMT_IMM8; end
                  3'd2: cycles = 5'h06;
                  3'd3: cycles = 5'h07;
                  3'd4: begin cycles = 5'h07; effect = EFF_RAM; end
                  3'd5: begin cycles = 5'h08; effect = EFF_RAM; end
                  3'd6: begin
                     len = 2'd3; cycles = 5'h09; fmt = FMT_ADDR_IMM; effect = EFF_RAM;
                  end
                  3'd7: begin
                     len = 2'd3; cycles = 5'h0A; fmt = FMT_ADDR_IMM; effect = EFF_RAM;
                  end
                  default: cycles = CYC_DEFAULT;
               endcase
            end
         end
      endcase
   end
endmodule
